// File: range_nco_pkg.sv
// Package with register map, field layouts, reset values and carriers for the range and oscillator block.
package range_nco_pkg;
    // ----------------------------------------
    // Register offsets (byte addresses = 4 x index)
    // ----------------------------------------
    localparam logic [11:0] REG_IDX_SELECT_MODE = 12'h020C;
    localparam logic [11:0] REG_IDX_PRESET_INDEX = 12'h020D;
    localparam logic [11:0] REG_IDX_CONTROL = 12'h0210;
    localparam logic [11:0] REG_IDX_LIMITS = 12'h0211;
    localparam logic [11:0] REG_IDX_IRQ_STATUS = 12'h0212;
    localparam logic [11:0] REG_IDX_IRQ_MASK = 12'h0213;
    localparam logic [11:0] REG_IDX_LIVE_STATUS = 12'h0214;
    localparam logic [11:0] REG_IDX_STEP_BASE = 12'h0220;
    localparam logic [11:0] REG_IDX_PHASE_BASE = 12'h0228;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int SELECT_SOURCE_BIT = 0;
    localparam int POWER_DOWN_BIT_POS = 0;
    localparam int WINDOW_EXP_LSB = 4;
    localparam int LIMIT_B_LSB = 8;
    localparam int IRQ_FLAG_A_BIT = 0;
    localparam int IRQ_FLAG_B_BIT = 1;
    localparam int IRQ_WINDOW_BIT = 2;
    // ----------------------------------------
    // Reset values and sizes
    // ----------------------------------------
    localparam logic [7:0] SELECT_MODE_RESET = 8'h00;
    localparam logic [7:0] PRESET_INDEX_RESET = 8'h00;
    localparam logic [7:0] LIMIT_A_RESET = 8'hFF;
    localparam logic [7:0] LIMIT_B_RESET = 8'hFF;
    localparam logic [2:0] WINDOW_EXP_RESET = 3'h0;
    localparam logic [31:0] STEP_RESET = 32'h0000_0000;
    localparam logic [15:0] PHASE_RESET = 16'h0000;
    localparam logic [11:0] MIDSCALE = 12'h0800;
    localparam int PRESET_COUNT = 8;
    localparam int PHASE_LUT_BITS = 6;
    localparam int SAMPLE_BITS = 15;
    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [14:0] value;
        logic flag;
    } word_out_t;
    typedef struct packed {
        word_out_t in_phase;
        word_out_t quadrature;
        logic valid;
    } complex_out_t;
endpackage : range_nco_pkg

// File: range_nco_core.sv
// Over-range monitor, eight-preset oscillator, complex mixer and output gating.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Fold each 12-bit sample to magnitude; compare top 8 bits with two limits.
// - Offset binary to two's complement, 11-bit magnitude; -2048 gives 2047, 2048 gives 0.
// - Flag set when any compared magnitude reaches its limit in the window, else clear.
// - Flag A sits in LSB of each I word, I value in upper 15 bits.
// - Flag B sits in LSB of each Q word, Q value in upper 15 bits.
// - Window length is two to the exponent samples, 1 up to 128.
// - Power-down bit high disables the serial output drivers.
// - A 32-bit tuned complex exponential multiplies real samples down to zero frequency.
// - Eight presets, each accumulator runs always; switching takes effect at once.
// - Preset index field sits in bits 2:0 at offset 0x20D.
// - Bit 0 at offset 0x20C picks pins (0) or register field (1).
// - Each accumulator has its own step word and phase word.
// - Output frequency is step word times 2^-32 times sample clock.
// - 16-bit phase word is left-justified to 32 bits and added to accumulator.
module range_nco_core
    import range_nco_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [11:0] sample_in,
    input wire logic [2:0] preset_select_pins,
    input wire logic [13:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    output complex_out_t sample_out,
    output logic serial_enable,
    output logic irq
);
    // ----------------------------------------
    // Register bus slave
    // ----------------------------------------
    logic [7:0] select_mode_q;
    logic [7:0] preset_index_q;
    logic power_down_bit_q;
    logic [2:0] range_window_exponent_q;
    logic [7:0] range_limit_a_q;
    logic [7:0] range_limit_b_q;
    logic [2:0] irq_status_q;
    logic [2:0] irq_mask_q;
    logic [31:0] tone_step_word_q [PRESET_COUNT];
    logic [15:0] tone_phase_word_q [PRESET_COUNT];
    logic ack_q;
    logic range_flag_a_q;
    logic range_flag_b_q;
    logic [2:0] irq_event;
    logic [11:0] reg_idx;
    logic wr_go;
    logic [31:0] rd_d;
    logic hit_d;

    assign reg_idx = address[13:2];
    assign wr_go = write && ack_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_q <= 1'b0;
            waitrequest <= 1'b1;
        end else begin
            ack_q <= (read || write) && !ack_q;
            waitrequest <= !((read || write) && !ack_q);
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        hit_d = 1'b1;
        if (reg_idx == REG_IDX_SELECT_MODE) begin
            rd_d = {24'h00_0000, select_mode_q};
        end else if (reg_idx == REG_IDX_PRESET_INDEX) begin
            rd_d = {24'h00_0000, preset_index_q};
        end else if (reg_idx == REG_IDX_CONTROL) begin
            rd_d = {25'h000_0000, range_window_exponent_q, 3'h0, power_down_bit_q};
        end else if (reg_idx == REG_IDX_LIMITS) begin
            rd_d = {16'h0000, range_limit_b_q, range_limit_a_q};
        end else if (reg_idx == REG_IDX_IRQ_STATUS) begin
            rd_d = {29'h0000_0000, irq_status_q};
        end else if (reg_idx == REG_IDX_IRQ_MASK) begin
            rd_d = {29'h0000_0000, irq_mask_q};
        end else if (reg_idx == REG_IDX_LIVE_STATUS) begin
            rd_d = {30'h0000_0000, range_flag_b_q, range_flag_a_q};
        end else if (reg_idx[11:3] == REG_IDX_STEP_BASE[11:3]) begin
            rd_d = tone_step_word_q[reg_idx[2:0]];
        end else if (reg_idx[11:3] == REG_IDX_PHASE_BASE[11:3]) begin
            rd_d = {16'h0000, tone_phase_word_q[reg_idx[2:0]]};
        end else begin
            hit_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
            response <= 2'h0;
        end else begin
            readdata <= (read && !ack_q) ? rd_d : 32'h0000_0000;
            response <= hit_d ? 2'h0 : 2'h2;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            select_mode_q <= SELECT_MODE_RESET;
            preset_index_q <= PRESET_INDEX_RESET;
            power_down_bit_q <= 1'b0;
            range_window_exponent_q <= WINDOW_EXP_RESET;
            range_limit_a_q <= LIMIT_A_RESET;
            range_limit_b_q <= LIMIT_B_RESET;
            irq_mask_q <= 3'h0;
        end else if (wr_go && byteenable[0]) begin
            if (reg_idx == REG_IDX_SELECT_MODE) begin
                select_mode_q <= writedata[7:0];
            end
            if (reg_idx == REG_IDX_PRESET_INDEX) begin
                preset_index_q <= writedata[7:0];
            end
            if (reg_idx == REG_IDX_CONTROL) begin
                power_down_bit_q <= writedata[POWER_DOWN_BIT_POS];
                range_window_exponent_q <= writedata[WINDOW_EXP_LSB +: 3];
            end
            if (reg_idx == REG_IDX_LIMITS) begin
                range_limit_a_q <= writedata[7:0];
            end
            if (reg_idx == REG_IDX_IRQ_MASK) begin
                irq_mask_q <= writedata[2:0];
            end
        end
        if (!rst && wr_go && byteenable[1] && reg_idx == REG_IDX_LIMITS) begin
            range_limit_b_q <= writedata[LIMIT_B_LSB +: 8];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PRESET_COUNT; gi++) begin : g_words
            always_ff @(posedge mclk) begin
                if (rst) begin
                    tone_step_word_q[gi] <= STEP_RESET;
                    tone_phase_word_q[gi] <= PHASE_RESET;
                end else if (wr_go) begin
                    for (int b = 0; b < 4; b++) begin
                        if (byteenable[b] && reg_idx == REG_IDX_STEP_BASE + 12'(gi)) begin
                            tone_step_word_q[gi][b*8 +: 8] <= writedata[b*8 +: 8];
                        end
                    end
                    for (int b = 0; b < 2; b++) begin
                        if (byteenable[b] && reg_idx == REG_IDX_PHASE_BASE + 12'(gi)) begin
                            tone_phase_word_q[gi][b*8 +: 8] <= writedata[b*8 +: 8];
                        end
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Interrupt status, write one to clear, set wins
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_status_q <= 3'h0;
            irq <= 1'b0;
        end else begin
            if (wr_go && byteenable[0] && reg_idx == REG_IDX_IRQ_STATUS) begin
                irq_status_q <= (irq_status_q & ~writedata[2:0]) | irq_event;
            end else begin
                irq_status_q <= irq_status_q | irq_event;
            end
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

    // ----------------------------------------
    // Over-range monitor
    // ----------------------------------------
    logic [11:0] sample_s1_q;
    logic [11:0] sample_s2_q;
    logic [11:0] twos;
    logic [10:0] magnitude;
    logic [7:0] mag_top;
    logic [6:0] win_count_q;
    logic [6:0] win_last;
    logic hit_a_q;
    logic hit_b_q;
    logic win_end;
    logic cur_a;
    logic cur_b;

    always_ff @(posedge mclk) begin
        if (rst) begin
            sample_s1_q <= MIDSCALE;
            sample_s2_q <= MIDSCALE;
        end else begin
            sample_s1_q <= sample_in;
            sample_s2_q <= sample_s1_q;
        end
    end

    assign twos = sample_s2_q ^ MIDSCALE;
    assign magnitude = !twos[11] ? twos[10:0] :
        ((twos[10:0] == 11'h000) ? 11'h7FF : 11'(~twos[10:0] + 11'h001));
    assign mag_top = magnitude[10:3];
    assign cur_a = mag_top >= range_limit_a_q;
    assign cur_b = mag_top >= range_limit_b_q;
    assign win_last = 7'((8'h01 << range_window_exponent_q) - 8'h01);
    assign win_end = win_count_q >= win_last;
    assign irq_event = {win_end, win_end & (hit_b_q | cur_b), win_end & (hit_a_q | cur_a)};

    always_ff @(posedge mclk) begin
        if (rst) begin
            win_count_q <= 7'h00;
            hit_a_q <= 1'b0;
            hit_b_q <= 1'b0;
            range_flag_a_q <= 1'b0;
            range_flag_b_q <= 1'b0;
        end else if (win_end) begin
            win_count_q <= 7'h00;
            hit_a_q <= 1'b0;
            hit_b_q <= 1'b0;
            range_flag_a_q <= hit_a_q | cur_a;
            range_flag_b_q <= hit_b_q | cur_b;
        end else begin
            win_count_q <= win_count_q + 7'h01;
            hit_a_q <= hit_a_q | cur_a;
            hit_b_q <= hit_b_q | cur_b;
        end
    end

    // ----------------------------------------
    // Oscillator presets and mixer
    // ----------------------------------------
    logic [31:0] accum_q [PRESET_COUNT];
    logic [2:0] active;
    logic [31:0] phase_now;
    logic [PHASE_LUT_BITS-1:0] lut_idx;
    logic signed [15:0] cos_v;
    logic signed [15:0] sin_v;
    logic signed [12:0] real_s;
    logic signed [28:0] prod_i;
    logic signed [28:0] prod_q;
    logic [2:0] pins_s1_q;
    logic [2:0] pins_s2_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            pins_s1_q <= 3'h0;
            pins_s2_q <= 3'h0;
        end else begin
            pins_s1_q <= preset_select_pins;
            pins_s2_q <= pins_s1_q;
        end
    end

    generate
        for (gi = 0; gi < PRESET_COUNT; gi++) begin : g_accum
            always_ff @(posedge mclk) begin
                if (rst) begin
                    accum_q[gi] <= 32'h0000_0000;
                end else begin
                    accum_q[gi] <= accum_q[gi] + tone_step_word_q[gi];
                end
            end
        end
    endgenerate

    assign active = select_mode_q[SELECT_SOURCE_BIT] ? preset_index_q[2:0] : pins_s2_q;
    assign phase_now = accum_q[active] + {tone_phase_word_q[active], 16'h0000};
    assign lut_idx = phase_now[31 -: PHASE_LUT_BITS];

    function automatic logic signed [15:0] sine_of(input logic [PHASE_LUT_BITS-1:0] p);
        real ang;
        ang = 6.283185307179586 * p / (2.0 ** PHASE_LUT_BITS);
        return 16'($rtoi(32767.0 * $sin(ang)));
    endfunction : sine_of

    logic signed [15:0] sine_rom [2**PHASE_LUT_BITS];
    generate
        for (gi = 0; gi < 2**PHASE_LUT_BITS; gi++) begin : g_rom
            assign sine_rom[gi] = sine_of(PHASE_LUT_BITS'(gi));
        end
    endgenerate

    assign cos_v = sine_rom[PHASE_LUT_BITS'(lut_idx + PHASE_LUT_BITS'(2**(PHASE_LUT_BITS-2)))];
    assign sin_v = sine_rom[lut_idx];
    assign real_s = {twos[11], twos};
    assign prod_i = real_s * cos_v;
    assign prod_q = -(real_s * sin_v);

    always_ff @(posedge mclk) begin
        if (rst) begin
            sample_out <= '0;
        end else begin
            sample_out.valid <= !power_down_bit_q;
            sample_out.in_phase.value <= prod_i[26 -: SAMPLE_BITS];
            sample_out.in_phase.flag <= range_flag_a_q;
            sample_out.quadrature.value <= prod_q[26 -: SAMPLE_BITS];
            sample_out.quadrature.flag <= range_flag_b_q;
        end
    end

    // ----------------------------------------
    // Power-down gating
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            serial_enable <= 1'b0;
        end else begin
            serial_enable <= !power_down_bit_q;
        end
    end
endmodule : range_nco_core
`default_nettype wire

// File: range_nco_chk_sva.sv
// Port checker for the range and oscillator core.
`timescale 1ns/100ps
`default_nettype none
module range_nco_chk
    import range_nco_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [13:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [1:0] response,
    input wire complex_out_t sample_out,
    input wire logic serial_enable
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic wr_ctl;
    logic [2:0] exp_q;
    logic [7:0] run_a_q;
    logic [7:0] run_b_q;
    assign wr_ctl = write && !waitrequest && byteenable[0] && address[13:2] == REG_IDX_CONTROL;
    // Tracks the window size and how long each flag has stood.
    always_ff @(posedge mclk) begin
        exp_q <= rst ? WINDOW_EXP_RESET : (wr_ctl ? writedata[6:4] : exp_q);
        run_a_q <= (rst || !sample_out.in_phase.flag) ? 8'h00 : run_a_q + 8'h01;
        run_b_q <= (rst || !sample_out.quadrature.flag) ? 8'h00 : run_b_q + 8'h01;
    end
    property p_wait_one; !waitrequest |=> waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low too long");
    property p_answer; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("no answer after one wait state");
    property p_rd_zero; waitrequest |-> readdata == 32'h0000_0000; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data not zero while waiting");
    property p_unmapped; !waitrequest && address[13:2] == 12'h300 |-> response == 2'b10; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_pd_valid; !serial_enable |-> !sample_out.valid; endproperty
    a_pd_valid: assert property (p_pd_valid) else $error("valid output while powered down");
    property p_pd_on; wr_ctl && writedata[0] |-> ##[1:2] !serial_enable; endproperty
    a_pd_on: assert property (p_pd_on) else $error("drivers left on in power down");
    property p_pd_off; wr_ctl && !writedata[0] |-> ##[1:2] serial_enable; endproperty
    a_pd_off: assert property (p_pd_off) else $error("drivers not back on");
    property p_win_a;
        $fell(sample_out.in_phase.flag) && sample_out.valid && $past(sample_out.valid)
            |-> (run_a_q & ((8'h01 << exp_q) - 8'h01)) == 8'h00;
    endproperty
    a_win_a: assert property (p_win_a) else $error("flag a not held whole windows");
    property p_win_b;
        $fell(sample_out.quadrature.flag) && sample_out.valid && $past(sample_out.valid)
            |-> (run_b_q & ((8'h01 << exp_q) - 8'h01)) == 8'h00;
    endproperty
    a_win_b: assert property (p_win_b) else $error("flag b not held whole windows");
endmodule : range_nco_chk
bind range_nco_core range_nco_chk range_nco_chk_i (.mclk, .rst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .response, .sample_out, .serial_enable);
`default_nettype wire

// File: sample_receiver.sv
// Receiver model that drops stale words after each link start.
`timescale 1ns/100ps
`default_nettype none
module sample_receiver
    import range_nco_pkg::*;
#(
    parameter int FLUSH_WORDS = 8
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire complex_out_t sample_out,
    input wire logic serial_enable,
    output logic [15:0] trusted_count
);
    logic [7:0] flush_q;
    logic [15:0] trusted_q;
    always_ff @(posedge mclk) begin
        if (rst || !serial_enable) begin
            flush_q <= 8'(FLUSH_WORDS);
        end else if (flush_q != 8'h00) begin
            flush_q <= flush_q - 8'h01;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            trusted_q <= 16'h0000;
        end else if (flush_q == 8'h00 && serial_enable && sample_out.valid) begin
            trusted_q <= trusted_q + 16'h0001;
        end
    end
    assign trusted_count = trusted_q;
endmodule : sample_receiver
`default_nettype wire

// File: overrange_flag_and_nco_select_bench.sv
// Self-checking testbench for the range and oscillator core.
`timescale 1ns/100ps
`default_nettype none
module overrange_flag_and_nco_select_bench;
    import range_nco_pkg::*;
    typedef struct packed {
        logic [11:0] smp;
        logic fa;
        logic fb;
    } row_t;
    row_t rows [7] = '{'{12'hFFF, 1'b1, 1'b1}, '{12'hFF0, 1'b1, 1'b1}, '{12'h800, 1'b0, 1'b0},
        '{12'h010, 1'b1, 1'b1}, '{12'h000, 1'b1, 1'b1}, '{12'hA00, 1'b0, 1'b1}, '{12'h9F8, 1'b0, 1'b0}};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] sample_in = MIDSCALE;
    logic [2:0] preset_select_pins = 3'h0;
    logic [13:0] address = 14'h0000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] response;
    complex_out_t sample_out;
    logic serial_enable;
    logic irq;
    logic [15:0] trusted_count;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [14:0] v [5];
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    int cnt;
    range_nco_core range_nco_core_i (.mclk, .rst, .sample_in, .preset_select_pins, .address, .read, .write,
        .writedata, .byteenable, .readdata, .waitrequest, .response, .sample_out, .serial_enable, .irq);
    sample_receiver #(.FLUSH_WORDS(8)) sample_receiver_i (.mclk, .rst, .sample_out, .serial_enable,
        .trusted_count);
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic end_sim;
        if (num_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= wd;
        @(posedge mclk);
        while (waitrequest !== 1'b0) @(posedge mclk);
        rd = readdata;
        rsp = response;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask : bus
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        bus(1'b1, REG_IDX_LIMITS, 32'h0000_40FE);
        foreach (rows[i]) begin
            sample_in <= rows[i].smp;
            repeat (8) @(posedge mclk);
            chk("flag_a", 32'(rows[i].fa), 32'(sample_out.in_phase.flag));
            chk("flag_b", 32'(rows[i].fb), 32'(sample_out.quadrature.flag));
        end
        bus(1'b0, REG_IDX_SELECT_MODE, 32'h0000_0000);
        chk("mode_reset", {24'h00_0000, SELECT_MODE_RESET}, rd);
        bus(1'b0, 12'h300, 32'h0000_0000);
        chk("unmapped", 32'h0000_0002, {30'h0000_0000, rsp});
        bus(1'b1, REG_IDX_PRESET_INDEX, 32'h0000_0005);
        bus(1'b0, REG_IDX_PRESET_INDEX, 32'h0000_0000);
        chk("preset_index", 32'h0000_0005, rd & 32'h0000_0007);
        for (int n = 0; n < 8; n++) begin
            bus(1'b1, REG_IDX_CONTROL, 32'(n) << 4);
            sample_in <= MIDSCALE;
            repeat (300) @(posedge mclk);
            sample_in <= 12'hFFF;
            @(posedge mclk);
            sample_in <= MIDSCALE;
            cnt = 0;
            repeat (300) begin
                @(posedge mclk);
                cnt += int'(sample_out.in_phase.flag === 1'b1) + int'(sample_out.quadrature.flag === 1'b1);
            end
            chk("window", 32'(2 << n), 32'(cnt));
        end
        bus(1'b1, REG_IDX_CONTROL, 32'h0000_0000);
        bus(1'b1, REG_IDX_IRQ_STATUS, 32'h0000_0007);
        bus(1'b1, REG_IDX_IRQ_MASK, 32'h0000_0001);
        sample_in <= 12'hFFF;
        repeat (4) @(posedge mclk);
        sample_in <= MIDSCALE;
        repeat (6) @(posedge mclk);
        chk("irq_set", 32'h0000_0001, 32'(irq));
        bus(1'b1, REG_IDX_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge mclk);
        chk("irq_mask", 32'h0000_0000, 32'(irq));
        bus(1'b0, REG_IDX_IRQ_STATUS, 32'h0000_0000);
        chk("irq_sticky", 32'h0000_0001, rd & 32'h0000_0001);
        bus(1'b1, REG_IDX_IRQ_STATUS, 32'h0000_0001);
        bus(1'b1, REG_IDX_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        chk("irq_clear", 32'h0000_0000, 32'(irq));
        sample_in <= 12'hC00;
        bus(1'b1, REG_IDX_STEP_BASE + 12'h001, 32'h4000_0000);
        bus(1'b1, REG_IDX_SELECT_MODE, 32'h0000_0000);
        preset_select_pins <= 3'h1;
        repeat (10) @(posedge mclk);
        for (int k = 0; k < 5; k++) begin
            v[k] = sample_out.in_phase.value;
            @(posedge mclk);
        end
        chk("period", 32'(v[0]), 32'(v[4]));
        chk("moving", 32'h0000_0001, 32'(v[1] !== v[0]));
        bus(1'b1, REG_IDX_PRESET_INDEX, 32'h0000_0000);
        bus(1'b1, REG_IDX_SELECT_MODE, 32'h0000_0001);
        repeat (10) @(posedge mclk);
        v[0] = sample_out.in_phase.value;
        @(posedge mclk);
        chk("reg_source", 32'(v[0]), 32'(sample_out.in_phase.value));
        chk("quad_zero", 32'h0000_0000, 32'(sample_out.quadrature.value));
        bus(1'b1, REG_IDX_PHASE_BASE, 32'h0000_4000);
        repeat (10) @(posedge mclk);
        chk("phase_turn", 32'h0000_0000, 32'(sample_out.in_phase.value));
        chk("quad_turn", 32'h0000_0001, 32'(sample_out.quadrature.value != 15'h0000));
        bus(1'b1, REG_IDX_CONTROL, 32'h0000_0001);
        repeat (4) @(posedge mclk);
        chk("pd_enable", 32'h0000_0000, 32'(serial_enable));
        chk("pd_valid", 32'h0000_0000, 32'(sample_out.valid));
        cnt = int'(trusted_count);
        bus(1'b1, REG_IDX_CONTROL, 32'h0000_0000);
        repeat (40) @(posedge mclk);
        chk("pd_release", 32'h0000_0001, 32'(serial_enable));
        cnt = int'(trusted_count) - cnt;
        chk("flushed", 32'h0000_0001, 32'(cnt > 0 && cnt < 40));
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        chk("reset_enable", 32'h0000_0000, 32'(serial_enable));
        chk("reset_irq", 32'h0000_0000, 32'(irq));
        rst <= 1'b0;
        @(posedge mclk);
        bus(1'b0, REG_IDX_LIMITS, 32'h0000_0000);
        chk("limits_reset", {16'h0000, LIMIT_B_RESET, LIMIT_A_RESET}, rd);
        bus(1'b0, REG_IDX_PHASE_BASE, 32'h0000_0000);
        chk("phase_reset", {16'h0000, PHASE_RESET}, rd);
        end_sim();
    end
endmodule : overrange_flag_and_nco_select_bench
`default_nettype wire
